// file: hdl/scb_decoder.sv
// Command byte decoder: register pointer, transfer type and special
// functions for a light sensor behind a serial register interface.
// Assumes a bit-level serial engine on mclk that reports transaction
// starts, received bytes and read byte requests as one-cycle pulses.
//
// How it works
// R1 - A command byte sets the register pointer used by later transfers.
// R2 - Only bytes with bit 7 set count as commands; host must set it.
// R3 - Type 00 keeps the pointer fixed for every data byte.
// R4 - Type 01 advances the pointer by one after each data byte.
// R5 - Type 10 is reserved; host never sends it, device ignores it.
// R6 - Type 11 runs the low five bits as a special function.
// R7 - Types 00 and 01 load the low five bits as the register number.
// R8 - Codes 05, 06, 07 clear proximity, color or both, as one pulse.
// R9 - Reads without a new command use the previously stored address.
// R10 - A first byte with bit 7 clear is data at the stored address.
// R11 - A raised measurement interrupt stays pending until its clear.
// R12 - Reset gives pointer zero, repeated-byte type, nothing pending.
`timescale 1ns/1ps
`include "scb_consts.svh"

module scb_decoder
  import scb_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            rst_b,
  input  wire logic            wr_start,
  input  wire logic            wr_byte_valid,
  input  wire logic [7:0]      wr_byte,
  input  wire logic            rd_byte_req,
  input  wire logic            xfer_stop,
  input  wire logic            prox_int_set,
  input  wire logic            color_int_set,
  output scb_addr_t            reg_ptr,
  output scb_kind_t            xfer_type,
  output scb_addr_t            acc_addr,
  output logic [7:0]           acc_wdata,
  output logic                 acc_wr,
  output logic                 acc_rd,
  output logic                 prox_clr,
  output logic                 color_clr,
  output logic                 bad_cmd,
  output logic                 prox_int,
  output logic                 color_int
);

  // A byte is a command only when its top bit is set.
  function automatic logic is_cmd(input logic [7:0] b);
    return b[`SCB_CMD_BIT];
  endfunction

  // Transfer type field of a command byte.
  function automatic scb_kind_t kind_of(input logic [7:0] b);
    return b[`SCB_TYPE_HI:`SCB_TYPE_LO];
  endfunction

  scb_phase_t phase;
  scb_kind_t  cmd_kind;
  scb_addr_t  cmd_field;
  logic       take_cmd;
  logic       take_data;
  logic       take_rd;
  logic       load_ptr;
  logic       run_sf;
  logic [`SCB_INT_N-1:0] clr_vec;
  logic [`SCB_INT_N-1:0] set_vec;
  logic [`SCB_INT_N-1:0] pend_vec;

  // Phase tracking: only the first byte of a write may be a command.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      phase <= SCB_PH_IDLE;
    end else if (wr_start) begin
      phase <= SCB_PH_CMD;
    end else if (xfer_stop) begin
      phase <= SCB_PH_IDLE;
    end else begin
      case (phase)
        SCB_PH_CMD: begin
          if (wr_byte_valid) begin
            phase <= SCB_PH_DATA;
          end
        end
        SCB_PH_DATA: phase <= SCB_PH_DATA;
        SCB_PH_IDLE: phase <= SCB_PH_IDLE;
        default:     phase <= SCB_PH_IDLE;
      endcase
    end
  end

  // Byte classification. A write byte takes priority over a read request
  // in the same cycle; the engine cannot produce both at once anyway.
  assign cmd_kind  = kind_of(wr_byte);
  assign cmd_field = wr_byte[`SCB_ADDR_HI:0];
  assign take_cmd  = (phase == SCB_PH_CMD) && wr_byte_valid
                     && is_cmd(wr_byte);                  // [R2]
  assign take_data = wr_byte_valid && ((phase == SCB_PH_DATA)
                     || ((phase == SCB_PH_CMD) && !is_cmd(wr_byte))); // [R10]
  assign take_rd   = rd_byte_req && !wr_byte_valid;       // [R9]
  assign load_ptr  = take_cmd && ((cmd_kind == `SCB_TYPE_REPEAT)
                     || (cmd_kind == `SCB_TYPE_AUTOINC)); // [R7]
  assign run_sf    = take_cmd && (cmd_kind == `SCB_TYPE_SPECIAL); // [R6]

  // Register pointer and transfer type. A reserved type or a special
  // function leaves both untouched, so a stray command cannot redirect
  // the following data bytes.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      reg_ptr   <= `SCB_PTR_RESET;                        // [R12]
      xfer_type <= `SCB_TYPE_RESET;                       // [R12]
    end else if (load_ptr) begin
      reg_ptr   <= cmd_field;                             // [R1] [R7]
      xfer_type <= cmd_kind;
    end else if ((take_data || take_rd)
                 && (xfer_type == `SCB_TYPE_AUTOINC)) begin
      reg_ptr   <= reg_ptr + `SCB_PTR_STEP;               // [R4]
    end else begin
      reg_ptr   <= reg_ptr;                               // [R3]
    end
  end

  // Register file access strobes with the address in force at the byte.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      acc_wr    <= 1'b0;
      acc_rd    <= 1'b0;
      acc_addr  <= `SCB_PTR_RESET;
      acc_wdata <= 8'h00;
    end else begin
      acc_wr <= take_data;                                // [R10]
      acc_rd <= take_rd;                                  // [R9]
      if (take_data || take_rd) begin
        acc_addr <= reg_ptr;                              // [R1]
      end
      if (take_data) begin
        acc_wdata <= wr_byte;
      end
    end
  end

  // Special codes 05, 06 and 07 fire one-cycle clear pulses; unknown codes and the
  // reserved type only raise bad_cmd, which helps firmware bring-up.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      prox_clr  <= 1'b0;
      color_clr <= 1'b0;
      bad_cmd   <= 1'b0;
    end else begin
      prox_clr  <= run_sf && ((cmd_field == `SCB_SF_PROX_CLR)
                   || (cmd_field == `SCB_SF_BOTH_CLR));   // [R8]
      color_clr <= run_sf && ((cmd_field == `SCB_SF_COLOR_CLR)
                   || (cmd_field == `SCB_SF_BOTH_CLR));   // [R8]
      bad_cmd   <= (take_cmd && (cmd_kind == `SCB_TYPE_RESV)) // [R5]
                   || (run_sf && (cmd_field != `SCB_SF_NOP)
                       && (cmd_field != `SCB_SF_PROX_CLR)
                       && (cmd_field != `SCB_SF_COLOR_CLR)
                       && (cmd_field != `SCB_SF_BOTH_CLR));
    end
  end

  assign clr_vec[`SCB_INT_PROX]  = prox_clr;
  assign clr_vec[`SCB_INT_COLOR] = color_clr;
  assign set_vec[`SCB_INT_PROX]  = prox_int_set;
  assign set_vec[`SCB_INT_COLOR] = color_int_set;

  // Pending measurement interrupts, held until the matching clear.
  scb_int_hold #(
    .N         (`SCB_INT_N)
  ) u_int_hold (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .set_pulse (set_vec),
    .clr_pulse (clr_vec),
    .pending   (pend_vec)
  );

  assign prox_int  = pend_vec[`SCB_INT_PROX];             // [R11]
  assign color_int = pend_vec[`SCB_INT_COLOR];            // [R11]

  // Checks on the decoder's own behaviour.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  sequence both_clr_s;
    prox_clr && color_clr;
  endsequence

  sequence clr_done_s;
    !prox_clr && !color_clr;
  endsequence

  ptr_load_a: assert property ( // [R1]
    load_ptr |=> reg_ptr == $past(cmd_field)
                 && xfer_type == $past(cmd_kind))
    else $error("Pointer not loaded from the command byte.");

  data_not_cmd_a: assert property ( // [R2]
    (phase == SCB_PH_CMD) && wr_byte_valid && !wr_byte[`SCB_CMD_BIT]
    |=> acc_wr && acc_wdata == $past(wr_byte))
    else $error("Byte with top bit clear was not taken as data.");

  ptr_fixed_a: assert property ( // [R3]
    (take_data || take_rd) && xfer_type == `SCB_TYPE_REPEAT
    |=> $stable(reg_ptr))
    else $error("Pointer moved in repeated-byte mode.");

  ptr_step_a: assert property ( // [R4]
    (take_data || take_rd) && xfer_type == `SCB_TYPE_AUTOINC
    |=> reg_ptr == $past(reg_ptr) + `SCB_PTR_STEP)
    else $error("Pointer did not advance in auto-increment mode.");

  resv_ignored_a: assert property ( // [R5]
    take_cmd && cmd_kind == `SCB_TYPE_RESV
    |=> $stable(reg_ptr) && $stable(xfer_type) && bad_cmd)
    else $error("Reserved command changed the pointer.");

  special_keep_a: assert property ( // [R6]
    run_sf |=> $stable(reg_ptr) && $stable(xfer_type))
    else $error("Special function altered the pointer.");

  both_clr_a: assert property ( // [R8]
    run_sf && cmd_field == `SCB_SF_BOTH_CLR
    ##1 !run_sf |-> both_clr_s ##1 clr_done_s)
    else $error("Combined clear did not pulse once.");

  nop_quiet_a: assert property ( // [R8]
    run_sf && cmd_field == `SCB_SF_NOP |=> !prox_clr && !color_clr)
    else $error("No-action code produced a clear.");

  read_addr_a: assert property ( // [R9]
    take_rd |=> acc_rd && acc_addr == $past(reg_ptr))
    else $error("Read used the wrong address.");

  write_addr_a: assert property ( // [R10]
    take_data |=> acc_wr && acc_addr == $past(reg_ptr))
    else $error("Write used the wrong address.");

  reset_state_a: assert property ( // [R12]
    $rose(rst_b) |-> reg_ptr == `SCB_PTR_RESET
                     && xfer_type == `SCB_TYPE_RESET
                     && !prox_int && !color_int)
    else $error("Decoder state wrong after reset.");

endmodule

// file: hdl/scb_consts.svh
// Constants for the serial command byte decoder: field positions,
// encodings and reset values.
// Assumes it is included by bare name from the package and the modules.
`ifndef SCB_CONSTS_SVH
`define SCB_CONSTS_SVH

// Command byte layout.
`define SCB_CMD_BIT      7
`define SCB_TYPE_HI      6
`define SCB_TYPE_LO      5
`define SCB_ADDR_HI      4
`define SCB_ADDR_W       5

// Transfer type encodings.
`define SCB_TYPE_REPEAT  2'h0
`define SCB_TYPE_AUTOINC 2'h1
`define SCB_TYPE_RESV    2'h2
`define SCB_TYPE_SPECIAL 2'h3

// Special function codes.
`define SCB_SF_NOP       5'h00
`define SCB_SF_PROX_CLR  5'h05
`define SCB_SF_COLOR_CLR 5'h06
`define SCB_SF_BOTH_CLR  5'h07

// Reset values and pointer step.
`define SCB_PTR_RESET    5'h00
`define SCB_TYPE_RESET   2'h0
`define SCB_PTR_STEP     5'h01

// Interrupt flag positions in the pending vectors.
`define SCB_INT_PROX     0
`define SCB_INT_COLOR    1
`define SCB_INT_N        2

`endif

// file: hdl/scb_pkg.sv
// Types shared by the serial command byte decoder modules.
// Assumes scb_consts.svh is on the include path.
`include "scb_consts.svh"

package scb_pkg;

  typedef logic [`SCB_ADDR_W-1:0] scb_addr_t;
  typedef logic [1:0]             scb_kind_t;

  // Where the decoder stands inside a host transaction.
  typedef enum logic [1:0] {
    SCB_PH_IDLE,
    SCB_PH_CMD,
    SCB_PH_DATA
  } scb_phase_t;

endpackage

// file: hdl/scb_int_hold.sv
// Pending interrupt holders for the proximity and color measurements.
// Assumes set pulses come from the persistence filter and clear pulses
// from the command decoder, all on mclk.
`timescale 1ns/1ps
`include "scb_consts.svh"

module scb_int_hold
  import scb_pkg::*;
#(
  parameter int N = `SCB_INT_N
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic [N-1:0] set_pulse,
  input  wire logic [N-1:0] clr_pulse,
  output logic      [N-1:0] pending
);

  // Each flag holds until its clear; a set in the clear cycle wins so
  // that a fresh measurement event is never lost.
  for (genvar i = 0; i < N; i++) begin : g_flag
    always_ff @(posedge mclk) begin
      if (!rst_b) begin
        pending[i] <= 1'b0;
      end else if (set_pulse[i]) begin
        pending[i] <= 1'b1;                          // [R11]
      end else if (clr_pulse[i]) begin
        pending[i] <= 1'b0;                          // [R8]
      end
    end

    flag_hold_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R11]
      pending[i] && !clr_pulse[i] |=> pending[i])
      else $error("Pending interrupt dropped without a clear.");

    set_wins_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R11]
      set_pulse[i] |=> pending[i])
      else $error("Interrupt set did not leave the flag pending.");
  end

endmodule

// file: testbench/scb_host_model.sv
// Serial host model: presents byte engine events to the decoder, one
// cycle per call. Assumes the caller calls put at a falling mclk edge.
`timescale 1ns/1ps
`include "scb_consts.svh"

module scb_host_model (
  input  wire logic       mclk,
  output logic            wr_start,
  output logic            wr_byte_valid,
  output logic [7:0]      wr_byte,
  output logic            rd_byte_req,
  output logic            xfer_stop
);
  logic [7:0] last_b = 8'h00;

  // Kinds: 1 start, 2 byte, 3 read request, 4 stop, other idle.
  // An idle byte lane shows the inverse of its last value, so a stale
  // byte can never pass for a fresh one.
  task automatic put(input int k, input logic [7:0] b);
    wr_start      = (k == 1);
    wr_byte_valid = (k == 2);
    rd_byte_req   = (k == 3);
    xfer_stop     = (k == 4);
    wr_byte       = (k == 2) ? b : ~last_b;
    last_b        = wr_byte;
  endtask

  // Builds a command byte; the host never uses the reserved type and
  // only sends the listed special codes.
  function automatic logic [7:0] mk_cmd(input logic [1:0] t,
                                        input logic [4:0] a);
    logic [1:0] tt;
    logic [4:0] aa;
    tt = (t == `SCB_TYPE_RESV) ? `SCB_TYPE_SPECIAL : t;
    aa = a;
    if (tt == `SCB_TYPE_SPECIAL && a != 5'h00 && a != 5'h05 &&
        a != 5'h06 && a != 5'h07) begin
      aa = `SCB_SF_NOP;
    end
    return {1'b1, tt, aa};
  endfunction
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the command byte decoder with a reference
// model kept in integers. Assumes the host model file is compiled first.
`timescale 1ns/1ps
`include "scb_consts.svh"

module testbench;
  import scb_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic wr_start, wr_byte_valid, rd_byte_req, xfer_stop;
  logic [7:0] wr_byte, acc_wdata;
  logic prox_int_set = 1'b0;
  logic color_int_set = 1'b0;
  scb_addr_t reg_ptr, acc_addr;
  scb_kind_t xfer_type;
  logic acc_wr, acc_rd, prox_clr, color_clr, bad_cmd, prox_int, color_int;
  int err_count = 0;
  int n_tests = 0;
  int mptr = 0, mtyp = 0, first = 0, mp = 0, mc = 0, dp = 0, dc = 0;

  scb_host_model i_scb_host_model (.mclk(mclk), .wr_start(wr_start),
    .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte),
    .rd_byte_req(rd_byte_req), .xfer_stop(xfer_stop));
  scb_decoder i_scb_decoder (.mclk(mclk), .rst_b(rst_b),
    .wr_start(wr_start), .wr_byte_valid(wr_byte_valid),
    .wr_byte(wr_byte), .rd_byte_req(rd_byte_req), .xfer_stop(xfer_stop),
    .prox_int_set(prox_int_set), .color_int_set(color_int_set),
    .reg_ptr(reg_ptr), .xfer_type(xfer_type), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_wr(acc_wr), .acc_rd(acc_rd),
    .prox_clr(prox_clr), .color_clr(color_clr), .bad_cmd(bad_cmd),
    .prox_int(prox_int), .color_int(color_int));

  // The clock toggles every 5 ns, a period of 10 ns.
  initial begin
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string n, input logic [7:0] s,
                     input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // One cycle of stimulus at a falling edge; kinds 5 and 6 raise the
  // proximity and color interrupts. Outputs are compared at the next falling edge.
  task automatic op(input int k, input logic [7:0] b);
    logic [4:0] ea;
    logic ew, er, ep, ec, eb;
    ew = 0;
    er = 0;
    ep = 0;
    ec = 0;
    eb = 0;
    ea = 0;
    i_scb_host_model.put(k, b);
    prox_int_set = (k == 5);
    color_int_set = (k == 6);
    if (dp) mp = 0;
    if (dc) mc = 0;
    if (k == 5) mp = 1;
    if (k == 6) mc = 1;
    if (k == 1) first = 1;
    if (k == 2 && first && b[7]) begin
      if (b[6:5] == `SCB_TYPE_RESV) begin
        // A reserved command leaves pointer and type alone.
        eb = 1;
      end else if (b[6:5] != `SCB_TYPE_SPECIAL) begin
        mptr = b[4:0];
        mtyp = b[6:5];
      end else begin
        ep = (b[4:0] == `SCB_SF_PROX_CLR || b[4:0] == `SCB_SF_BOTH_CLR);
        ec = (b[4:0] == `SCB_SF_COLOR_CLR || b[4:0] == `SCB_SF_BOTH_CLR);
        eb = (b[4:0] != `SCB_SF_NOP && b[4:0] != `SCB_SF_PROX_CLR
              && b[4:0] != `SCB_SF_COLOR_CLR
              && b[4:0] != `SCB_SF_BOTH_CLR);
      end
    end else if (k == 2 || k == 3) begin
      ea = mptr[4:0];
      ew = (k == 2);
      er = (k == 3);
      if (mtyp == 1) mptr = (mptr + 1) % 32;
    end
    if (k == 2) first = 0;
    dp = ep;
    dc = ec;
    @(negedge mclk);
    chk("acc_wr", acc_wr, ew);
    chk("acc_rd", acc_rd, er);
    chk("prox_clr", prox_clr, ep);
    chk("color_clr", color_clr, ec);
    chk("bad_cmd", bad_cmd, eb);
    chk("reg_ptr", reg_ptr, mptr[4:0]);
    chk("xfer_type", xfer_type, mtyp[1:0]);
    chk("prox_int", prox_int, mp);
    chk("color_int", color_int, mc);
    if (ew || er) chk("acc_addr", acc_addr, ea);
    if (ew) chk("acc_wdata", acc_wdata, b);
  endtask

  // A hang is cut short well beyond the few hundred cycles needed.
  initial begin
    #200us;
    err_count++;
    end_sim();
  end

  initial begin
    logic [7:0] sc [4];
    sc = '{8'he5, 8'he6, 8'he7, 8'he0};
    i_scb_host_model.put(0, 8'h00);
    void'($urandom(32'hc4c0f24d));
    repeat (4) @(negedge mclk);
    rst_b = 1'b1;
    op(0, 0);
    $display("test reset done");
    op(1, 0);
    op(2, i_scb_host_model.mk_cmd(2'h1, 5'h1f));
    repeat (3) op(2, 8'($urandom));
    op(4, 0);
    $display("test auto increment and wrap done");
    op(1, 0);
    op(2, i_scb_host_model.mk_cmd(2'h0, 5'h05));
    repeat (3) op(2, 8'h80 | 8'($urandom));
    repeat (3) op(3, 0);
    op(4, 0);
    $display("test repeated byte done");
    op(1, 0);
    op(2, 8'h12);
    op(2, 8'h34);
    op(4, 0);
    $display("test data first done");
    // A well-behaved host never sends these two; they are driven here on
    // purpose to see that the decoder flags them and keeps its pointer.
    op(1, 0);
    op(2, 8'hc9);
    op(2, 8'h3c);
    op(4, 0);
    op(1, 0);
    op(2, 8'hea);
    op(4, 0);
    $display("test refused commands done");
    foreach (sc[i]) begin
      op(5, 0);
      op(6, 0);
      op(1, 0);
      op(2, i_scb_host_model.mk_cmd(sc[i][6:5], sc[i][4:0]));
      op(4, 0);
      op(0, 0);
    end
    $display("test interrupt clears done");
    repeat (40) begin
      op(1, 0);
      op(2, i_scb_host_model.mk_cmd(2'($urandom), 5'($urandom)));
      repeat ($urandom % 4) op(2, 8'($urandom));
      repeat ($urandom % 4) op(3 + 2 * ($urandom % 2), 0);
      op(4, 0);
    end
    $display("test random transactions done");
    // A second reset in mid-run must drop a moved pointer and a pending
    // interrupt, so the reset values are not just left over from power-up.
    op(1, 0);
    op(2, i_scb_host_model.mk_cmd(2'h1, 5'h0a));
    op(4, 0);
    op(5, 0);
    op(0, 0);
    rst_b = 1'b0;
    repeat (4) @(negedge mclk);
    rst_b = 1'b1;
    mptr = 0;
    mtyp = 0;
    mp = 0;
    mc = 0;
    dp = 0;
    dc = 0;
    first = 0;
    op(0, 0);
    $display("test mid-run reset done");
    op(0, 0);
    end_sim();
  end
endmodule
